// ==== dv/sdrcfg_mem_model.sv ====
// memory device stand-in: strobe reference and extended mode register capture
// assumes the controller clock and reset of the block under test
`timescale 1ns/1ps
module sdrcfg_mem_model (
  // controller side
  input wire clock,
  input wire rst_n,
  input wire strobe_on,
  input wire emr_load_q,
  input wire [7:0] emr_value_q,
  // strobe pin and captured state
  output reg dqs_ref,
  output reg [7:0] emr_q,
  output reg [7:0] emr_cnt
);
  // strobe stands still between bursts; odd phase keeps it unrelated to clock
  initial begin
    dqs_ref = 1'b0;
    #3.3;
    forever begin
      #62.5;
      if (strobe_on) dqs_ref = ~dqs_ref;
    end
  end
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      emr_q <= 8'h00;
      emr_cnt <= 8'h00;
    end else if (emr_load_q) begin
      emr_q <= emr_value_q;
      emr_cnt <= emr_cnt + 8'h01;
    end
  end
endmodule

// ==== dv/sdrcfg_monitor.sv ====
// assertions on the ports of the configuration block
// assumes one clock domain, bound into sdrcfg_top
`timescale 1ns/1ps
module sdrcfg_monitor (
  // clock and apb
  input wire clock,
  input wire rst_n,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata_q,
  input wire pready_q,
  input wire pslverr_q,
  // low power
  input wire xfer_req,
  input wire cke_q,
  input wire mem_clk_run_q,
  input wire sref_enter_q,
  input wire pdown_enter_q,
  input wire dpd_enter_q,
  input wire lp_exit_q,
  input wire lp_active_q,
  input wire emr_load_q,
  input wire [3:0] refresh_bank_mask_q,
  input wire [2:0] memory_type_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire ent = sref_enter_q | pdown_enter_q | dpd_enter_q;
  property p_ans; psel && !penable && ce |=> pready_q; endproperty
  a_ans: assert property (p_ans) else $error("apb answer missing");
  property p_err; pslverr_q |-> pready_q && prdata_q == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error without answer");
  property p_ent; ent |-> !$past(xfer_req) && !xfer_req; endproperty
  a_ent: assert property (p_ent) else $error("entry while busy");
  property p_cke; $fell(cke_q) |-> ent && lp_active_q; endproperty
  a_cke: assert property (p_cke) else $error("cke fell without entry");
  property p_exit; !cke_q && xfer_req && ce |=> cke_q && lp_exit_q; endproperty
  a_exit: assert property (p_exit) else $error("no exit on request");
  property p_lpq; lp_exit_q |=> !lp_active_q; endproperty
  a_lpq: assert property (p_lpq) else $error("still in low power");
  property p_clk; !mem_clk_run_q |-> lp_active_q && !cke_q; endproperty
  a_clk: assert property (p_clk) else $error("clock stopped while active");
  property p_mask; (refresh_bank_mask_q == 4'hf) || (refresh_bank_mask_q == 4'h3) || (refresh_bank_mask_q == 4'h1);
  endproperty
  a_mask: assert property (p_mask) else $error("bad bank mask");
  property p_dpd; dpd_enter_q |-> memory_type_q == 3'h1 || memory_type_q == 3'h3; endproperty
  a_dpd: assert property (p_dpd) else $error("deep power-down on wrong type");
  c_sref: cover property (sref_enter_q);
  c_emr: cover property (emr_load_q);
  c_exit: cover property (lp_exit_q);
endmodule
bind sdrcfg_top sdrcfg_monitor u_mon (.clock, .rst_n, .ce, .psel, .penable, .prdata_q, .pready_q, .pslverr_q,
  .xfer_req, .cke_q, .mem_clk_run_q, .sref_enter_q, .pdown_enter_q, .dpd_enter_q, .lp_exit_q, .lp_active_q,
  .emr_load_q, .refresh_bank_mask_q, .memory_type_q);

// ==== dv/sdrcfg_top_tb_top.sv ====
// self-checking bench for the sdram configuration block
// assumes the memory stand-in drives the strobe reference pin
`timescale 1ns/1ps
module sdrcfg_top_tb_top;
  reg clock, rst_n, ce, psel, penable, pwrite, init_done, xfer_req, refresh_tick, strobe_on, err;
  reg [7:0] paddr, n0;
  reg [31:0] pwdata, rd;
  reg [2:0] t;
  wire [31:0] prdata_q;
  wire pready_q, pslverr_q, dqs_ref, cke_q, mem_clk_run_q, sref_enter_q, pdown_enter_q, dpd_enter_q;
  wire lp_exit_q, lp_active_q, emr_load_q, bus_width_sel_q, read_anticipation_off_q;
  wire [7:0] emr_value_q, dqs_delay_tap_q, emr_q, emr_cnt;
  wire [3:0] refresh_bank_mask_q;
  wire [2:0] memory_type_q;
  wire [127:0] pad_delay_elements_q;
  integer fail_count, n_tests, i, c;
  sdrcfg_top dut (.clock, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q,
    .pready_q, .pslverr_q, .init_done, .xfer_req, .refresh_tick, .dqs_ref, .cke_q, .mem_clk_run_q,
    .sref_enter_q, .pdown_enter_q, .dpd_enter_q, .lp_exit_q, .lp_active_q, .emr_load_q, .emr_value_q,
    .refresh_bank_mask_q, .dqs_delay_tap_q, .memory_type_q, .bus_width_sel_q, .read_anticipation_off_q,
    .pad_delay_elements_q);
  sdrcfg_mem_model mem (.clock, .rst_n, .strobe_on, .emr_load_q, .emr_value_q, .dqs_ref, .emr_q, .emr_cnt);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task chk(input [31:0] e, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (e !== g) begin
        fail_count = fail_count + 1;
        $display("Error t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  endtask
  // request held until pready is seen high at an edge
  task apb(input w, input [7:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      k = 0;
      @(posedge clock);
      // no limit here: only the watchdog ends a hung transfer; wait states are counted
      while (pready_q !== 1'b1) begin
        k = k + 1;
        @(posedge clock);
      end
      chk(0, k);
      rd = prdata_q;
      err = pslverr_q;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // c counts edges until the watched event, sel picks emr load over entry
  task wait_sig(input sel, input integer lim);
    begin
      c = 0;
      @(posedge clock);
      while ((sel ? emr_load_q : (sref_enter_q | pdown_enter_q | dpd_enter_q)) !== 1'b1 && c < lim) begin
        c = c + 1;
        @(posedge clock);
      end
    end
  endtask
  task t_rst;
    begin
      apb(0, 8'h00, 0);
      chk(32'h0001_0000, rd);
      apb(0, 8'h04, 0);
      chk(32'h10, rd);
      apb(0, 8'h0c, 0);
      chk(32'h4, rd);
      apb(0, 8'h10, 0);
      chk(0, rd);
      apb(0, 8'h20, 0);
      chk(0, rd);
      chk(3'b111, {cke_q, bus_width_sel_q, read_anticipation_off_q});
      apb(0, 8'h40, 0);
      chk(1, err);
      chk(0, rd);
      $display("reset test done");
    end
  endtask
  task t_wp;
    begin
      apb(1, 8'h20, 32'h1);
      apb(0, 8'h20, 0);
      chk(0, rd);
      apb(1, 8'h20, 32'h4444_5201);
      apb(0, 8'h20, 0);
      chk(1, rd);
      apb(1, 8'h04, 32'h6);
      apb(1, 8'h0c, 32'h0);
      apb(0, 8'h04, 0);
      chk(32'h10, rd);
      apb(0, 8'h0c, 0);
      chk(32'h4, rd);
      apb(1, 8'h20, 32'h4444_5200);
      for (i = 0; i < 4; i = i + 1) begin
        t = (12'hcc8 >> (3 * i)) & 3'h7;
        apb(1, 8'h04, t);
        apb(0, 8'h04, 0);
        chk(t, rd);
        chk(t, memory_type_q);
      end
      apb(1, 8'h04, 32'h11);
      apb(1, 8'h0c, 32'h0);
      apb(0, 8'h0c, 0);
      chk(0, rd);
      chk(6'b001101, {memory_type_q, bus_width_sel_q, read_anticipation_off_q, cke_q});
      $display("protect test done");
    end
  endtask
  task t_dly;
    begin
      for (i = 0; i < 4; i = i + 1)
        apb(1, 8'h10 + 4 * i, 32'h8765_4321 + i);
      for (i = 0; i < 4; i = i + 1) begin
        apb(0, 8'h10 + 4 * i, 0);
        chk(32'h8765_4321 + i, rd);
        chk(32'h8765_4321 + i, pad_delay_elements_q[32 * i +: 32]);
      end
      $display("delay test done");
    end
  endtask
  task t_dll;
    begin
      strobe_on <= 1'b1;
      repeat (24) @(posedge clock);
      apb(0, 8'h08, 0);
      chk(1, rd[2:0]);
      repeat (400) @(posedge clock);
      apb(1, 8'h08, 32'hffff_ffff);
      apb(0, 8'h08, 0);
      chk(8'h06, rd[15:8]);
      chk(0, rd[2]);
      chk(8'h03, dqs_delay_tap_q);
      strobe_on <= 1'b0;
      $display("dll test done");
    end
  endtask
  task t_lp(input [1:0] cmd, input frz, input [1:0] tmo, input integer lim, input brk, input [3:0] exp);
    begin
      apb(1, 8'h00, 32'h0001_0000 | (tmo << 12) | (frz << 2) | cmd);
      @(posedge clock);
      xfer_req <= 1'b0;
      if (brk) begin
        repeat (30) @(posedge clock);
        xfer_req <= 1'b1;
        @(posedge clock);
        xfer_req <= 1'b0;
        // a frozen block must not count idle cycles, so the window below stays the same
        ce <= 1'b0;
        repeat (20) @(posedge clock);
        ce <= 1'b1;
      end
      wait_sig(0, lim + 8);
      chk(1, c >= lim + 1 && c <= lim + 3);
      chk(exp, {sref_enter_q, pdown_enter_q, dpd_enter_q, mem_clk_run_q});
      xfer_req <= 1'b1;
      repeat (2) @(posedge clock);
      chk(2'b11, {cke_q, lp_exit_q});
      $display("low power test done");
    end
  endtask
  task t_emr;
    begin
      apb(1, 8'h00, 32'h0001_3002);
      @(posedge clock);
      xfer_req <= 1'b0;
      wait_sig(0, 200);
      chk(200, c);
      xfer_req <= 1'b1;
      n0 = emr_cnt;
      apb(1, 8'h00, 32'h0021_0611);
      @(posedge clock);
      xfer_req <= 1'b0;
      wait_sig(1, 20);
      chk(8'hb1, emr_value_q);
      @(posedge clock);
      chk(1, sref_enter_q);
      chk(n0 + 8'h01, emr_cnt);
      // the bank mask follows one cycle after the low-power flag
      @(posedge clock);
      chk(4'h3, refresh_bank_mask_q);
      xfer_req <= 1'b1;
      apb(1, 8'h00, 32'h0011_0a10);
      for (i = 0; i < 3; i = i + 1) begin
        if (i > 0)
          apb(1, 8'h00, i > 1 ? 32'h0031_0210 : 32'h0001_0610);
        n0 = emr_cnt;
        refresh_tick <= 1'b1;
        @(posedge clock);
        refresh_tick <= 1'b0;
        @(posedge clock);
        chk(i == 0, emr_load_q);
        repeat (3) @(posedge clock);
        chk(i == 0 ? 8'hd1 : 8'hb1 ^ 8'h60, emr_q);
        chk(n0 + (i == 0), emr_cnt);
      end
      $display("mode register test done");
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    #200000;
    fail_count = fail_count + 1;
    final_report;
  end
  initial begin
    fail_count = 0;
    n_tests = 0;
    {rst_n, psel, penable, pwrite, init_done, refresh_tick, strobe_on} = 7'h0;
    xfer_req = 1'b1;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    t_rst;
    t_wp;
    t_dly;
    t_dll;
    init_done <= 1'b1;
    t_lp(2'h2, 1'b0, 2'h0, 0, 1'b0, 4'b0101);
    t_lp(2'h2, 1'b1, 2'h1, 64, 1'b1, 4'b0100);
    t_lp(2'h1, 1'b0, 2'h2, 128, 1'b0, 4'b1000);
    t_lp(2'h3, 1'b0, 2'h0, 0, 1'b0, 4'b0011);
    t_emr;
    final_report;
  end
endmodule

// ==== hdl/sdrcfg_defines.vh ====
// constants of the sdram controller configuration block: offsets, fields, resets, counts
// assumes inclusion by bare name from every design file of the block
`ifndef SDRCFG_DEFINES_VH
`define SDRCFG_DEFINES_VH

// register byte offsets on the apb window
`define SDRCFG_LPC_OFS 8'h00
`define SDRCFG_MDC_OFS 8'h04
`define SDRCFG_DLS_OFS 8'h08
`define SDRCFG_HSC_OFS 8'h0c
`define SDRCFG_IOD_OFS 8'h10
`define SDRCFG_WPM_OFS 8'h20

// low_power_ctrl fields
`define SDRCFG_F_LPCMD 1:0
`define SDRCFG_B_CLKFR 2
`define SDRCFG_F_PARTIAL_ARRAY_REFRESH 6:4
`define SDRCFG_F_TCR 9:8
`define SDRCFG_F_DS 11:10
`define SDRCFG_F_TMO 13:12
`define SDRCFG_B_ACTIVE_POWERDOWN_EXIT 16
`define SDRCFG_F_UPD 21:20
`define SDRCFG_LPC_MASK 32'h0033_3f77
`define SDRCFG_EMR_MASK 32'h0001_0f70
`define SDRCFG_LPC_RST 32'h0001_0000

// memory_device_cfg fields
`define SDRCFG_F_MTYPE 2:0
`define SDRCFG_B_DBW 4
`define SDRCFG_MDC_MASK 32'h0000_0017
`define SDRCFG_MDC_RST 32'h0000_0010

// high_speed_ctrl fields
`define SDRCFG_B_ANTOFF 2
`define SDRCFG_HSC_MASK 32'h0000_0004
`define SDRCFG_HSC_RST 32'h0000_0004
`define SDRCFG_IOD_RST 32'h0000_0000

// write protect
`define SDRCFG_WP_KEY 24'h444452
`define SDRCFG_F_WRITE_PROTECT_KEY 31:8

// memory types
`define SDRCFG_MT_SDR 3'h0
`define SDRCFG_MT_LPSDR 3'h1
`define SDRCFG_MT_LPDDR 3'h3
`define SDRCFG_MT_DDR2 3'h6

// low-power commands and update policies
`define SDRCFG_LP_OFF 2'h0
`define SDRCFG_LP_SREF 2'h1
`define SDRCFG_LP_PDOWN 2'h2
`define SDRCFG_LP_DPD 2'h3
`define SDRCFG_UPD_SHARED 2'h1
`define SDRCFG_UPD_PRIVATE 2'h2

// idle timeout counts in clock cycles
`define SDRCFG_TMO_NOW 8'h00
`define SDRCFG_TMO_64 8'h40
`define SDRCFG_TMO_128 8'h80

// dll master counter ceiling
`define SDRCFG_DLL_MAX 8'hff

`endif

// ==== hdl/sdrcfg_dll.v ====
// master delay tracker: counts the half period of the strobe reference and steers
// a master delay counter toward it; assumes ref_sync already passed two flip-flops
`timescale 1ns/1ps
`include "sdrcfg_defines.vh"

module sdrcfg_dll (
  // clock and reset
  input wire clock,
  input wire rst_n,
  input wire ce,
  // synchronised reference level
  input wire ref_sync,
  // status
  output reg [7:0] master_delay_count,
  output reg master_delay_up,
  output reg master_delay_down,
  output reg master_delay_overflow,
  output reg master_locked
);

  reg ref_prev_q;
  reg [7:0] half_cnt_q;
  reg sat_q;
  wire edge_seen;

  assign edge_seen = ref_sync ^ ref_prev_q;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ref_prev_q <= 1'b0;
      half_cnt_q <= 8'h00;
      sat_q <= 1'b0;
      master_delay_count <= 8'h00;
      master_delay_up <= 1'b0;
      master_delay_down <= 1'b0;
      master_delay_overflow <= 1'b0;
      master_locked <= 1'b0;
    end else if (ce) begin
      ref_prev_q <= ref_sync;
      if (edge_seen) begin
        // the edge cycle counts too, so the measure equals the edge spacing in clocks
        half_cnt_q <= 8'h01;
        sat_q <= 1'b0;
        // a reference slower than the counter range pins the master at its ceiling
        if (master_delay_count == `SDRCFG_DLL_MAX) begin
          master_delay_up <= 1'b0;
          master_delay_down <= 1'b0;
          master_delay_overflow <= 1'b1;
          master_locked <= 1'b1;
        end else if (sat_q || master_delay_count < half_cnt_q) begin
          master_delay_count <= master_delay_count + 8'h01;
          master_delay_up <= 1'b1;
          master_delay_down <= 1'b0;
          master_locked <= 1'b0;
        end else if (master_delay_count > half_cnt_q) begin
          master_delay_count <= master_delay_count - 8'h01;
          master_delay_up <= 1'b0;
          master_delay_down <= 1'b1;
          master_locked <= 1'b0;
          master_delay_overflow <= 1'b0;
        end else begin
          master_delay_up <= 1'b0;
          master_delay_down <= 1'b0;
          master_locked <= 1'b1;
          master_delay_overflow <= 1'b0;
        end
      end else if (half_cnt_q == `SDRCFG_DLL_MAX) begin
        sat_q <= 1'b1;
      end else begin
        half_cnt_q <= half_cnt_q + 8'h01;
      end
    end
  end

endmodule

// ==== hdl/sdrcfg_top.v ====
// configuration and low-power sequencing of an sdram controller, with apb registers
// assumes same-clock command logic drives xfer_req, refresh_tick and init_done;
// the strobe reference arrives from a pin and is synchronised here
`timescale 1ns/1ps
`include "sdrcfg_defines.vh"

// Behaviour
// - clock freeze stops memory clocks in power-down
// - partial array field masks refreshed banks
// - emr field change triggers automatic rewrite
// - temperature field passed into emr value
// - drive strength field passed into emr
// - idle timeout: immediate, 64, 128 cycles
// - powerdown exit bit: 0 fast, 1 slow
// - policy 01 updates at refresh with access
// - policy 10 updates before self refresh
// - memory type encodes device protocol
// - bus width bit, 16 bits at reset
// - protected registers ignore writes when locked
// - dll delays strobe to centre window
// - status bits show counter up/down
// - counter at maximum stops, locks, flags
// - master counter value readable bits 8-15
// - read anticipation off bit, default one
// - software spreads buffers across banks
// - four delay registers, eight 4-bit fields
// - low-power command selects mode
module sdrcfg_top (
  // clock, reset, enable
  input wire clock,
  input wire rst_n,
  input wire ce,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  // controller side, same clock
  input wire init_done,
  input wire xfer_req,
  input wire refresh_tick,
  // strobe reference pin
  input wire dqs_ref,
  // memory control
  output reg cke_q,
  output reg mem_clk_run_q,
  output reg sref_enter_q,
  output reg pdown_enter_q,
  output reg dpd_enter_q,
  output reg lp_exit_q,
  output reg lp_active_q,
  output reg emr_load_q,
  output reg [7:0] emr_value_q,
  output reg [3:0] refresh_bank_mask_q,
  output reg [7:0] dqs_delay_tap_q,
  // configuration out
  output reg [2:0] memory_type_q,
  output reg bus_width_sel_q,
  output reg read_anticipation_off_q,
  output reg [127:0] pad_delay_elements_q
);

  localparam ST_ACT = 3'h0;
  localparam ST_EMR = 3'h1;
  localparam ST_ENT = 3'h2;
  localparam ST_LP = 3'h3;
  localparam ST_EXT = 3'h4;

  reg [31:0] lpc_q;
  reg [31:0] mdc_q;
  reg [31:0] hsc_q;
  reg [31:0] iod_q [0:3];
  reg write_protect_on_q;
  reg ref_s1_q;
  reg ref_s2_q;
  reg [2:0] state_q;
  reg [7:0] idle_cnt_q;
  reg emr_pend_q;
  reg [1:0] lp_mode_q;

  wire [7:0] master_delay_count;
  wire master_delay_up;
  wire master_delay_down;
  wire master_delay_overflow;
  wire master_locked;

  wire acc_phase;
  wire wr_en;
  wire wr_lpc;
  wire emr_changed;
  wire [1:0] low_power_cmd;
  wire [1:0] auto_mode_reg_update;
  wire [1:0] tmo_sel;
  wire lp_type;
  wire lp_allowed;
  wire tmo_valid;
  reg [7:0] tmo_limit;
  wire idle_done;
  wire emr_at_refresh;
  wire emr_before_sref;
  reg [31:0] rd_mux;
  reg rd_hit;
  integer i;

  assign acc_phase = psel & penable & pready_q;
  assign wr_en = acc_phase & pwrite & ce;
  assign wr_lpc = wr_en & (paddr == `SDRCFG_LPC_OFS);
  assign low_power_cmd = lpc_q[`SDRCFG_F_LPCMD];
  assign auto_mode_reg_update = lpc_q[`SDRCFG_F_UPD];
  assign tmo_sel = lpc_q[`SDRCFG_F_TMO];
  assign lp_type = (mdc_q[`SDRCFG_F_MTYPE] == `SDRCFG_MT_LPSDR) || (mdc_q[`SDRCFG_F_MTYPE] == `SDRCFG_MT_LPDDR);

  // change of any field mirrored in the extended mode register
  assign emr_changed = wr_lpc && (((pwdata ^ lpc_q) & `SDRCFG_EMR_MASK) != 32'h0000_0000);

  // deep power-down is meaningful for low-power parts only
  assign lp_allowed = init_done && (low_power_cmd != `SDRCFG_LP_OFF) &&
                      ((low_power_cmd != `SDRCFG_LP_DPD) || lp_type);

  always @* begin
    case (tmo_sel)
      2'h0: tmo_limit = `SDRCFG_TMO_NOW;
      2'h1: tmo_limit = `SDRCFG_TMO_64;
      2'h2: tmo_limit = `SDRCFG_TMO_128;
      default: tmo_limit = `SDRCFG_TMO_NOW;
    endcase
  end

  assign tmo_valid = (tmo_sel != 2'h3);
  assign idle_done = tmo_valid && !xfer_req && (idle_cnt_q >= tmo_limit);

  // reserved policy 11 never issues an update
  assign emr_at_refresh = emr_pend_q && (auto_mode_reg_update == `SDRCFG_UPD_SHARED) &&
                          refresh_tick && xfer_req;
  assign emr_before_sref = emr_pend_q && (auto_mode_reg_update == `SDRCFG_UPD_PRIVATE) &&
                           (low_power_cmd == `SDRCFG_LP_SREF);

  // the strobe reference is asynchronous; only the second stage feeds the tracker
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
    end else if (ce) begin
      ref_s1_q <= dqs_ref;
      ref_s2_q <= ref_s1_q;
    end
  end

  sdrcfg_dll u_dll (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .ref_sync(ref_s2_q),
    .master_delay_count(master_delay_count),
    .master_delay_up(master_delay_up),
    .master_delay_down(master_delay_down),
    .master_delay_overflow(master_delay_overflow),
    .master_locked(master_locked)
  );

  // read decode
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      `SDRCFG_LPC_OFS: rd_mux = lpc_q;
      `SDRCFG_MDC_OFS: rd_mux = mdc_q;
      `SDRCFG_DLS_OFS: rd_mux = {16'h0000, master_delay_count, 5'h00, master_delay_overflow,
                                 master_delay_down, master_delay_up};
      `SDRCFG_HSC_OFS: rd_mux = hsc_q;
      8'h10: rd_mux = iod_q[0];
      8'h14: rd_mux = iod_q[1];
      8'h18: rd_mux = iod_q[2];
      8'h1c: rd_mux = iod_q[3];
      `SDRCFG_WPM_OFS: rd_mux = {31'h0000_0000, write_protect_on_q};
      default: rd_hit = 1'b0;
    endcase
  end

  // apb: one wait-free access cycle, answer registered from the setup cycle
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (ce) begin
      if (psel && !penable && !pready_q) begin
        pready_q <= 1'b1;
        pslverr_q <= ~rd_hit;
        prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      end else begin
        pready_q <= 1'b0;
        pslverr_q <= 1'b0;
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // register writes
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lpc_q <= `SDRCFG_LPC_RST;
      mdc_q <= `SDRCFG_MDC_RST;
      hsc_q <= `SDRCFG_HSC_RST;
      write_protect_on_q <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        iod_q[i] <= `SDRCFG_IOD_RST;
      end
    end else if (wr_en) begin
      if (paddr == `SDRCFG_LPC_OFS) begin
        lpc_q <= pwdata & `SDRCFG_LPC_MASK;
      end
      if (paddr == `SDRCFG_MDC_OFS && !write_protect_on_q) begin
        mdc_q <= pwdata & `SDRCFG_MDC_MASK;
      end
      if (paddr == `SDRCFG_HSC_OFS && !write_protect_on_q) begin
        hsc_q <= pwdata & `SDRCFG_HSC_MASK;
      end
      if (paddr[7:4] == 4'h1) begin
        iod_q[paddr[3:2]] <= pwdata;
      end
      if (paddr == `SDRCFG_WPM_OFS && pwdata[`SDRCFG_F_WRITE_PROTECT_KEY] == `SDRCFG_WP_KEY) begin
        write_protect_on_q <= pwdata[0];
      end
    end
  end

  // low-power sequencer
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_ACT;
      idle_cnt_q <= 8'h00;
      emr_pend_q <= 1'b0;
      lp_mode_q <= `SDRCFG_LP_OFF;
      cke_q <= 1'b1;
      mem_clk_run_q <= 1'b1;
      sref_enter_q <= 1'b0;
      pdown_enter_q <= 1'b0;
      dpd_enter_q <= 1'b0;
      lp_exit_q <= 1'b0;
      lp_active_q <= 1'b0;
      emr_load_q <= 1'b0;
    end else if (ce) begin
      sref_enter_q <= 1'b0;
      pdown_enter_q <= 1'b0;
      dpd_enter_q <= 1'b0;
      lp_exit_q <= 1'b0;
      emr_load_q <= 1'b0;
      case (state_q)
        ST_ACT: begin
          if (xfer_req) begin
            idle_cnt_q <= 8'h00;
          end else if (idle_cnt_q != `SDRCFG_TMO_128) begin
            idle_cnt_q <= idle_cnt_q + 8'h01;
          end
          if (emr_at_refresh) begin
            emr_load_q <= 1'b1;
          end else if (lp_allowed && idle_done) begin
            lp_mode_q <= low_power_cmd;
            state_q <= emr_before_sref ? ST_EMR : ST_ENT;
          end
        end
        ST_EMR: begin
          emr_load_q <= 1'b1;
          state_q <= ST_ENT;
        end
        ST_ENT: begin
          cke_q <= 1'b0;
          lp_active_q <= 1'b1;
          sref_enter_q <= (lp_mode_q == `SDRCFG_LP_SREF);
          pdown_enter_q <= (lp_mode_q == `SDRCFG_LP_PDOWN);
          dpd_enter_q <= (lp_mode_q == `SDRCFG_LP_DPD);
          // self refresh always stops the clocks; the power-down modes only when frozen
          mem_clk_run_q <= !((lp_mode_q == `SDRCFG_LP_SREF) || lpc_q[`SDRCFG_B_CLKFR]);
          state_q <= ST_LP;
        end
        ST_LP: begin
          if (xfer_req || !lp_allowed) begin
            cke_q <= 1'b1;
            mem_clk_run_q <= 1'b1;
            lp_exit_q <= 1'b1;
            state_q <= ST_EXT;
          end
        end
        ST_EXT: begin
          lp_active_q <= 1'b0;
          idle_cnt_q <= 8'h00;
          state_q <= ST_ACT;
        end
        default: begin
          state_q <= ST_ACT;
        end
      endcase
      // a field change in the same cycle as an issue keeps the update pending
      if (emr_changed && init_done && (lpc_q[`SDRCFG_F_UPD] == `SDRCFG_UPD_SHARED ||
          lpc_q[`SDRCFG_F_UPD] == `SDRCFG_UPD_PRIVATE || pwdata[`SDRCFG_F_UPD] == `SDRCFG_UPD_SHARED ||
          pwdata[`SDRCFG_F_UPD] == `SDRCFG_UPD_PRIVATE)) begin
        emr_pend_q <= 1'b1;
      end else if (emr_at_refresh || state_q == ST_EMR) begin
        emr_pend_q <= 1'b0;
      end
    end
  end

  // registered copies of configuration for the controller datapath
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      emr_value_q <= 8'h00;
      refresh_bank_mask_q <= 4'hf;
      dqs_delay_tap_q <= 8'h00;
      memory_type_q <= `SDRCFG_MT_SDR;
      bus_width_sel_q <= 1'b1;
      read_anticipation_off_q <= 1'b1;
      pad_delay_elements_q <= 128'h0;
    end else if (ce) begin
      emr_value_q <= {lpc_q[`SDRCFG_B_ACTIVE_POWERDOWN_EXIT], lpc_q[`SDRCFG_F_DS], lpc_q[`SDRCFG_F_TCR],
                      lpc_q[`SDRCFG_F_PARTIAL_ARRAY_REFRESH]};
      // banks left out of partial-array refresh while a low-power part self refreshes
      if (lp_type && lp_active_q && lp_mode_q == `SDRCFG_LP_SREF) begin
        case (lpc_q[`SDRCFG_F_PARTIAL_ARRAY_REFRESH])
          3'h1: refresh_bank_mask_q <= 4'h3;
          3'h2: refresh_bank_mask_q <= 4'h1;
          default: refresh_bank_mask_q <= 4'hf;
        endcase
      end else begin
        refresh_bank_mask_q <= 4'hf;
      end
      // half the master delay centres the strobe in the data eye
      dqs_delay_tap_q <= {1'b0, master_delay_count[7:1]};
      memory_type_q <= mdc_q[`SDRCFG_F_MTYPE];
      bus_width_sel_q <= mdc_q[`SDRCFG_B_DBW];
      read_anticipation_off_q <= hsc_q[`SDRCFG_B_ANTOFF];
      pad_delay_elements_q <= {iod_q[3], iod_q[2], iod_q[1], iod_q[0]};
    end
  end

endmodule
